/* core/time_base_params.svh */
// constants for the motor pwm time base block
`ifndef TIME_BASE_PARAMS_SVH
`define TIME_BASE_PARAMS_SVH
`define NUM_BASES    2
`define VAL_W        15
`define REG_W        16
`define ADDR_W       8
`define CTL_RUN      15
`define CTL_IDLE     13
`define CTL_POST_HI  7
`define CTL_POST_LO  4
`define CTL_PRE_HI   3
`define CTL_PRE_LO   2
`define CTL_MODE_HI  1
`define CTL_MODE_LO  0
`define CTL_WMASK    16'ha0ff
`define CNT_DIR      15
`define RST_16       16'h0000
`define RD_PAD       16'h0000
`define OFS_CTRL     8'h00
`define OFS_COUNT    8'h04
`define OFS_PERIOD   8'h08
`define OFS_STEP     8'h10
`define OFS_STAT     8'h20
`define OFS_CLR      8'h24
`define OFS_EN       8'h28
`define MODE_FREE    2'h0
`define MODE_SINGLE  2'h1
`define MODE_UPDN    2'h2
`define MODE_DOUBLE  2'h3
`define PRE_DIV1     2'h0
`define PRE_DIV4     2'h1
`define PRE_DIV16    2'h2
`define PRE_LIM1     6'h00
`define PRE_LIM4     6'h03
`define PRE_LIM16    6'h0f
`define PRE_LIM64    6'h3f
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

/* core/time_base_pkg.sv */
// types shared by the time base counter and its register wrapper
`include "time_base_params.svh"
package time_base_pkg;
  typedef struct packed {
    logic              run_enable;
    logic              idle_stop;
    logic [3:0]        postscale;
    logic [1:0]        prescale;
    logic [1:0]        mode;
  } base_ctrl_s;
  typedef struct packed {
    logic [`VAL_W-1:0] count;
    logic              dir;
    logic              period_match;
    logic              base_event;
  } base_status_s;
endpackage

/* core/time_base_counter.sv */
// one pwm time base: prescaler, counter with direction, postscaler
`timescale 1ns/1ps
`include "time_base_params.svh"
module time_base_counter (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire time_base_pkg::base_ctrl_s    cfg,
  input  wire logic [`VAL_W-1:0]            period,
  input  wire logic                         cpu_idle,
  input  wire logic                         load_valid,
  input  wire logic [`VAL_W-1:0]            load_value,
  output wire logic                         single_done,
  output wire time_base_pkg::base_status_s  status
);
  logic              run;
  logic              tick;
  logic              updown;
  logic              top_hit;
  logic              bot_hit;
  logic              boundary;
  logic [5:0]        pre_lim;
  logic [5:0]        presc_reg;
  logic [`VAL_W-1:0] cnt_reg;
  logic              dir_reg;
  logic [3:0]        post_reg;
  logic              match_reg;
  logic              event_reg;

  assign run = cfg.run_enable && !(cfg.idle_stop && cpu_idle);

  always_comb begin
    case (cfg.prescale)
      `PRE_DIV1:  pre_lim = `PRE_LIM1;
      `PRE_DIV4:  pre_lim = `PRE_LIM4;
      `PRE_DIV16: pre_lim = `PRE_LIM16;
      default:    pre_lim = `PRE_LIM64;
    endcase
  end

  // one instruction cycle is one aclk
  assign tick = run && (presc_reg >= pre_lim);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= 6'h00;
    end else if (run) begin
      presc_reg <= tick ? 6'h00 : presc_reg + 6'h01;
    end
  end

  assign updown  = (cfg.mode == `MODE_UPDN) || (cfg.mode == `MODE_DOUBLE);
  assign top_hit = tick && !dir_reg && (cnt_reg >= period);
  assign bot_hit = tick && dir_reg && (cnt_reg == '0);
  assign single_done = top_hit && (cfg.mode == `MODE_SINGLE) && !load_valid;

  always_comb begin
    case (cfg.mode)
      `MODE_UPDN:   boundary = bot_hit;
      `MODE_DOUBLE: boundary = top_hit || bot_hit;
      default:      boundary = top_hit;
    endcase
  end

  // software load wins over counting in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      dir_reg <= 1'b0;
    end else if (load_valid) begin
      cnt_reg <= load_value;
    end else if (tick) begin
      if (!updown) begin
        dir_reg <= 1'b0;
        cnt_reg <= top_hit ? '0 : cnt_reg + 15'h0001;
      end else if (top_hit) begin
        dir_reg <= 1'b1;
        if (cnt_reg != '0) cnt_reg <= cnt_reg - 15'h0001;
      end else if (bot_hit) begin
        dir_reg <= 1'b0;
        if (period != '0) cnt_reg <= cnt_reg + 15'h0001;
      end else if (dir_reg) begin
        cnt_reg <= cnt_reg - 15'h0001;
      end else begin
        cnt_reg <= cnt_reg + 15'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post_reg  <= 4'h0;
      event_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      event_reg <= boundary && (post_reg >= cfg.postscale);
      match_reg <= top_hit;
      if (boundary) post_reg <= (post_reg >= cfg.postscale) ? 4'h0 : post_reg + 4'h1;
    end
  end

  assign status = '{count: cnt_reg, dir: dir_reg, period_match: match_reg,
                    base_event: event_reg};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_halt_disabled: assert property (
    !cfg.run_enable && !load_valid |=> $stable(cnt_reg))
    else $error("count moved while time base off");
  chk_halt_idle: assert property (
    cfg.idle_stop && cpu_idle && !load_valid |=> $stable(cnt_reg) && $stable(presc_reg))
    else $error("count moved in idle with idle stop set");
  chk_prescale_four: assert property (
    (tick && cfg.prescale == `PRE_DIV4) ##1 (run && cfg.prescale == `PRE_DIV4)[*4] |-> tick)
    else $error("prescale 1:4 spacing wrong");
  chk_free_wrap: assert property (
    top_hit && cfg.mode == `MODE_FREE && !load_valid |=> cnt_reg == '0 && !dir_reg)
    else $error("free run did not restart");
  chk_turn_top: assert property (
    top_hit && updown && !load_valid |=> dir_reg)
    else $error("no turn at period");
  chk_turn_bottom: assert property (
    bot_hit && updown && !load_valid |=> !dir_reg)
    else $error("no turn at zero");
  chk_double_event: assert property (
    cfg.mode == `MODE_DOUBLE && bot_hit && post_reg >= cfg.postscale |=> event_reg)
    else $error("double update mode missed a turning point");
  chk_dir_up_only: assert property (
    tick && !updown && !load_valid |=> !dir_reg)
    else $error("direction set in edge mode");
  chk_postscale_fire: assert property (
    boundary && post_reg >= cfg.postscale |=> event_reg ##1 !event_reg || boundary)
    else $error("postscaler did not fire");
endmodule

/* core/motor_pwm_time_base.sv */
// two motor pwm time bases behind an axi4-lite register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "time_base_params.svh"
module motor_pwm_time_base (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         cpu_idle,
  input  wire logic [`ADDR_W-1:0]           awaddr,
  input  wire logic [2:0]                   awprot,
  input  wire logic                         awvalid,
  output wire logic                         awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output wire logic                         wready,
  output wire logic [1:0]                   bresp,
  output wire logic                         bvalid,
  input  wire logic                         bready,
  input  wire logic [`ADDR_W-1:0]           araddr,
  input  wire logic [2:0]                   arprot,
  input  wire logic                         arvalid,
  output wire logic                         arready,
  output wire logic [31:0]                  rdata,
  output wire logic [1:0]                   rresp,
  output wire logic                         rvalid,
  input  wire logic                         rready,
  output wire logic                         irq,
  output wire time_base_pkg::base_status_s  base_status [`NUM_BASES]
);
  logic                     aw_full_reg;
  logic [`ADDR_W-1:0]       aw_addr_reg;
  logic                     w_full_reg;
  logic [`REG_W-1:0]        w_data_reg;
  logic [1:0]               w_strb_reg;
  logic                     bvalid_reg;
  logic [1:0]               bresp_reg;
  logic                     rvalid_reg;
  logic [`REG_W-1:0]        rdata_reg;
  logic [1:0]               rresp_reg;
  logic                     do_write;
  logic                     rd_take;
  logic [`REG_W-1:0]        rd_val;
  logic [`REG_W-1:0]        ctrl_reg   [`NUM_BASES];
  logic [`VAL_W-1:0]        period_reg [`NUM_BASES];
  time_base_pkg::base_ctrl_s cfg       [`NUM_BASES];
  logic [`NUM_BASES-1:0]    single_done;
  logic [`NUM_BASES-1:0]    base_event;
  logic [`NUM_BASES-1:0]    stat_reg;
  logic [`NUM_BASES-1:0]    stat_next;
  logic [`NUM_BASES-1:0]    en_reg;
  logic                     clr_hit;
  logic                     en_hit;

  // byte lanes 0 and 1 carry the 16-bit registers; upper lanes ignored
  function automatic logic [`REG_W-1:0] merge(input logic [`REG_W-1:0] old,
                                              input logic [`REG_W-1:0] val,
                                              input logic [1:0]        strb);
    logic [`REG_W-1:0] mask;
    mask = {{8{strb[1]}}, {8{strb[0]}}};
    return (old & ~mask) | (val & mask);
  endfunction

  function automatic logic addr_ok(input logic [`ADDR_W-1:0] a);
    logic ok;
    ok = (a == `OFS_STAT) || (a == `OFS_CLR) || (a == `OFS_EN);
    for (int k = 0; k < `NUM_BASES; k++) begin
      ok = ok || (a == `ADDR_W'(`OFS_CTRL + `OFS_STEP * k))
              || (a == `ADDR_W'(`OFS_COUNT + `OFS_STEP * k))
              || (a == `ADDR_W'(`OFS_PERIOD + `OFS_STEP * k));
    end
    return ok;
  endfunction

  // write channel: address and data are held until both are present
  assign awready  = !aw_full_reg;
  assign wready   = !w_full_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= `RST_16;
      w_strb_reg <= 2'h0;
    end else if (wvalid && wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= wdata[`REG_W-1:0];
      w_strb_reg <= wstrb[1:0];
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= addr_ok(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  // per time base registers and counter
  for (genvar i = 0; i < `NUM_BASES; i++) begin : g_base
    localparam logic [`ADDR_W-1:0] BASE = `ADDR_W'(`OFS_STEP * i);
    logic              ctl_hit;
    logic              cnt_hit;
    logic              per_hit;
    logic [`REG_W-1:0] cnt_word;
    logic [`REG_W-1:0] per_word;

    assign ctl_hit  = do_write && (aw_addr_reg == (`OFS_CTRL + BASE));
    assign cnt_hit  = do_write && (aw_addr_reg == (`OFS_COUNT + BASE));
    assign per_hit  = do_write && (aw_addr_reg == (`OFS_PERIOD + BASE));
    assign cnt_word = merge({1'b0, base_status[i].count}, w_data_reg, w_strb_reg);
    assign per_word = merge({1'b0, period_reg[i]}, w_data_reg, w_strb_reg);

    // a software write in the same cycle beats the single pulse stop
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_reg[i] <= `RST_16;
      end else if (ctl_hit) begin
        ctrl_reg[i] <= merge(ctrl_reg[i], w_data_reg, w_strb_reg) & `CTL_WMASK;
      end else if (single_done[i]) begin
        ctrl_reg[i][`CTL_RUN] <= 1'b0;
      end
    end

    // no shadow: a new period acts on the next compare
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        period_reg[i] <= '0;
      end else if (per_hit) begin
        period_reg[i] <= per_word[`VAL_W-1:0];
      end
    end

    assign cfg[i] = '{run_enable: ctrl_reg[i][`CTL_RUN],
                      idle_stop:  ctrl_reg[i][`CTL_IDLE],
                      postscale:  ctrl_reg[i][`CTL_POST_HI:`CTL_POST_LO],
                      prescale:   ctrl_reg[i][`CTL_PRE_HI:`CTL_PRE_LO],
                      mode:       ctrl_reg[i][`CTL_MODE_HI:`CTL_MODE_LO]};

    time_base_counter u_counter (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .cfg         (cfg[i]),
      .period      (period_reg[i]),
      .cpu_idle    (cpu_idle),
      .load_valid  (cnt_hit),
      .load_value  (cnt_word[`VAL_W-1:0]),
      .single_done (single_done[i]),
      .status      (base_status[i])
    );

    assign base_event[i] = base_status[i].base_event;
  end

  // interrupt status: sticky, write one to clear, set beats clear
  assign clr_hit = do_write && (aw_addr_reg == `OFS_CLR);
  assign en_hit  = do_write && (aw_addr_reg == `OFS_EN);

  always_comb begin
    stat_next = stat_reg;
    if (clr_hit) stat_next = stat_next & ~w_data_reg[`NUM_BASES-1:0];
    stat_next = stat_next | base_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg <= '0;
    end else if (en_hit && w_strb_reg[0]) begin
      en_reg <= w_data_reg[`NUM_BASES-1:0];
    end
  end

  assign irq = |(stat_reg & en_reg);

  // read channel: one read at a time, answered one cycle after it is taken
  assign arready = !rvalid_reg;
  assign rd_take = arvalid && arready;

  always_comb begin
    rd_val = `RST_16;
    for (int k = 0; k < `NUM_BASES; k++) begin
      if (araddr == `ADDR_W'(`OFS_CTRL + `OFS_STEP * k)) begin
        rd_val = ctrl_reg[k];
      end
      if (araddr == `ADDR_W'(`OFS_COUNT + `OFS_STEP * k)) begin
        rd_val = {base_status[k].dir, base_status[k].count};
      end
      if (araddr == `ADDR_W'(`OFS_PERIOD + `OFS_STEP * k)) begin
        rd_val = {1'b0, period_reg[k]};
      end
    end
    if (araddr == `OFS_STAT) rd_val[`NUM_BASES-1:0] = stat_reg;
    if (araddr == `OFS_EN) rd_val[`NUM_BASES-1:0] = en_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= `RST_16;
      rresp_reg  <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_val;
      rresp_reg  <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata  = {`RD_PAD, rdata_reg};
  assign rresp  = rresp_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_period_msb_zero: assert property (
    rd_take && araddr == `OFS_PERIOD
    |=> rdata[`REG_W-1:0] == {1'b0, $past(period_reg[0])})
    else $error("period read wrong or top bit set");

  chk_count_readback: assert property (
    rd_take && araddr == `OFS_COUNT
    |=> rdata_reg == {$past(base_status[0].dir), $past(base_status[0].count)})
    else $error("count read does not show live count and direction");

  chk_count_load: assert property (
    do_write && aw_addr_reg == `OFS_COUNT && (&w_strb_reg)
    |=> base_status[0].count == $past(w_data_reg[`VAL_W-1:0]))
    else $error("count write not loaded");

  chk_period_live: assert property (
    do_write && aw_addr_reg == `OFS_PERIOD && (&w_strb_reg) && ctrl_reg[0][`CTL_RUN]
    && !single_done[0]
    |=> period_reg[0] == $past(w_data_reg[`VAL_W-1:0]) && ctrl_reg[0][`CTL_RUN])
    else $error("period change while running failed");

  chk_single_stop: assert property (
    single_done[0] && !(do_write && aw_addr_reg == `OFS_CTRL)
    |=> !ctrl_reg[0][`CTL_RUN] ##1 $stable(base_status[0].count))
    else $error("single pulse did not stop");

  chk_bases_apart: assert property (
    do_write && aw_addr_reg == `OFS_CTRL + `OFS_STEP && !single_done[0]
    |=> $stable(ctrl_reg[0]))
    else $error("second base write disturbed first");

  chk_event_sticky: assert property (
    base_event[0] && en_reg[0] && !en_hit |=> stat_reg[0] && irq)
    else $error("event lost or interrupt missing");

  chk_unmapped_err: assert property (
    do_write && !addr_ok(aw_addr_reg) |=> bvalid && bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");

  chk_dir_kept: assert property (
    do_write && aw_addr_reg == `OFS_COUNT |=> base_status[0].dir == $past(base_status[0].dir))
    else $error("count write moved direction");

  chk_base1_apart: assert property (
    do_write && aw_addr_reg == `OFS_COUNT && !cfg[1].run_enable
    |=> $stable(base_status[1].count))
    else $error("first base write moved second base");

  chk_base1_period: assert property (
    do_write && aw_addr_reg == `OFS_PERIOD |=> $stable(period_reg[1]))
    else $error("first base period write moved second base");

  chk_clear_status: assert property (
    clr_hit && w_data_reg[0] && !base_event[0] |=> !stat_reg[0])
    else $error("status bit not cleared");

  chk_irq_enabled: assert property (
    stat_reg[0] && en_reg[0] |-> irq)
    else $error("enabled status without interrupt");

  chk_irq_masked: assert property (
    en_reg == '0 |-> !irq)
    else $error("interrupt while all masked");

  chk_status_read: assert property (
    rd_take && araddr == `OFS_STAT |=> rdata[`NUM_BASES-1:0] == $past(stat_reg))
    else $error("status read wrong");

  chk_enable_write: assert property (
    en_hit && w_strb_reg[0] |=> en_reg == $past(w_data_reg[`NUM_BASES-1:0]))
    else $error("enable write not stored");

  chk_ctrl_write: assert property (
    do_write && aw_addr_reg == `OFS_CTRL && (&w_strb_reg)
    |=> ctrl_reg[0] == ($past(w_data_reg) & `CTL_WMASK))
    else $error("control write not stored");

  chk_ctrl_reserved: assert property (
    (ctrl_reg[0] & ~`CTL_WMASK) == '0)
    else $error("reserved control bit set");

  chk_unmapped_read: assert property (
    rd_take && !addr_ok(araddr) |=> rresp == `RESP_SLVERR && rdata == '0)
    else $error("unmapped read not refused");

  cov_single_done: cover property (single_done[0]);
  cov_double_mode: cover property (cfg[0].mode == `MODE_DOUBLE && base_event[0]);
  cov_irq_rise:    cover property ($rose(irq));
  cov_second_base: cover property (base_event[1]);
  cov_idle_halt:   cover property (cfg[0].idle_stop && cpu_idle && cfg[0].run_enable);
endmodule

/* testbench/motor_pwm_time_base_tb.sv */
// self-checking bench for the two pwm time bases and their register slave
`timescale 1ns/1ps
`include "time_base_params.svh"
module motor_pwm_time_base_tb;
  logic                        aclk;
  logic                        aresetn;
  logic                        cpu_idle;
  logic [`ADDR_W-1:0]          awaddr;
  logic                        awvalid;
  logic                        awready;
  logic [31:0]                 wdata;
  logic [3:0]                  wstrb;
  logic                        wvalid;
  logic                        wready;
  logic [1:0]                  bresp;
  logic                        bvalid;
  logic                        bready;
  logic [`ADDR_W-1:0]          araddr;
  logic                        arvalid;
  logic                        arready;
  logic [31:0]                 rdata;
  logic [1:0]                  rresp;
  logic                        rvalid;
  logic                        rready;
  logic                        irq;
  time_base_pkg::base_status_s base_status [`NUM_BASES];
  int                          n_errors;
  int                          check_count;

  motor_pwm_time_base u_dut (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .cpu_idle    (cpu_idle),
    .awaddr      (awaddr),
    .awprot      (3'h0),
    .awvalid     (awvalid),
    .awready     (awready),
    .wdata       (wdata),
    .wstrb       (wstrb),
    .wvalid      (wvalid),
    .wready      (wready),
    .bresp       (bresp),
    .bvalid      (bvalid),
    .bready      (bready),
    .araddr      (araddr),
    .arprot      (3'h0),
    .arvalid     (arvalid),
    .arready     (arready),
    .rdata       (rdata),
    .rresp       (rresp),
    .rvalid      (rvalid),
    .rready      (rready),
    .irq         (irq),
    .base_status (base_status)
  );

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic a_ok;
    logic w_ok;
    a_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'h1;
    wdata   <= {16'h0000, d};
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      if (!a_ok && awready === 1'h1) begin
        a_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_ok && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    check("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er,
                    input string what);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    check(what, {16'h0000, exp}, rdata);
    check("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'h0;
  endtask

  function automatic logic [15:0] ctl(input logic run, input logic idle, input logic [3:0] post,
                                      input logic [1:0] pre, input logic [1:0] mode);
    return {run, 1'h0, idle, 5'h00, post, pre, mode};
  endfunction

  // skip two pulses so a config change has settled, then time the next gap
  task automatic gap_of(input int b, output int g);
    repeat (2) begin
      do @(posedge aclk); while (base_status[b].base_event !== 1'h1);
    end
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (base_status[b].base_event !== 1'h1);
  endtask

  initial begin
    logic [7:0]  rst_addr [6];
    logic [3:0]  post_set [3];
    logic [14:0] c0;
    logic        seen_down;
    int          g;
    int          q;
    int          pm;
    rst_addr = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h28};
    post_set = '{4'h0, 4'h1, 4'hf};
    n_errors = 0;
    check_count = 0;
    aresetn = 1'h0;
    cpu_idle = 1'h0;
    awaddr = 8'h00;
    awvalid = 1'h0;
    wdata = 32'h0;
    wstrb = 4'h3;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 8'h00;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rst_addr[i]) rd(rst_addr[i], 16'h0000, `RESP_OKAY, "reset value");
    rd(8'h3c, 16'h0000, `RESP_SLVERR, "unmapped read");
    wr(8'h3c, 16'hffff, `RESP_SLVERR);
    wr(`OFS_CTRL, 16'h7fff, `RESP_OKAY);
    rd(`OFS_CTRL, 16'h20ff, `RESP_OKAY, "control layout");
    wr(`OFS_PERIOD, 16'hffff, `RESP_OKAY);
    rd(`OFS_PERIOD, 16'h7fff, `RESP_OKAY, "period top bit");
    wstrb <= 4'h1;
    wr(`OFS_PERIOD, 16'h1234, `RESP_OKAY);
    wstrb <= 4'h3;
    rd(`OFS_PERIOD, 16'h7f34, `RESP_OKAY, "period low lane only");
    wr(`OFS_PERIOD, 16'h0002, `RESP_OKAY);
    wr(`OFS_CTRL, 16'h0000, `RESP_OKAY);
    wr(`OFS_COUNT, 16'h8005, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(`OFS_COUNT, 16'h0005, `RESP_OKAY, "count load, stopped");
    // period 2: free wraps every 3 ticks, up/down turns at zero every 4, double every 2
    for (int m = 0; m < 4; m++) begin
      if (m != 1) begin
        wr(`OFS_CTRL, ctl(1'h1, 1'h0, 4'h0, 2'h0, m[1:0]), `RESP_OKAY);
        gap_of(0, g);
        check("mode gap", (m == 0) ? 3 : (m == 2) ? 4 : 2, g);
      end
    end
    for (int p = 0; p < 4; p++) begin
      wr(`OFS_CTRL, ctl(1'h1, 1'h0, 4'h0, p[1:0], 2'h0), `RESP_OKAY);
      gap_of(0, g);
      check("prescale gap", 3 * (1 << (2 * p)), g);
    end
    foreach (post_set[i]) begin
      wr(`OFS_CTRL, ctl(1'h1, 1'h0, post_set[i], 2'h0, 2'h0), `RESP_OKAY);
      gap_of(0, g);
      check("postscale gap", 3 * (post_set[i] + 1), g);
    end
    wr(`OFS_CTRL, ctl(1'h1, 1'h0, 4'h0, 2'h0, 2'h0), `RESP_OKAY);
    wr(`OFS_PERIOD, 16'h0004, `RESP_OKAY);
    gap_of(0, g);
    check("period change running", 5, g);
    wr(`OFS_CTRL, ctl(1'h1, 1'h0, 4'h0, 2'h0, 2'h2), `RESP_OKAY);
    repeat (4) @(posedge aclk);
    c0 = base_status[0].count;
    seen_down = 1'h0;
    repeat (40) begin
      @(posedge aclk);
      if (base_status[0].count !== c0) begin
        check("dir vs slope", {31'h0, base_status[0].count < c0}, {31'h0, base_status[0].dir});
        check("count within period", 1, {31'h0, base_status[0].count <= 15'h0004});
        c0 = base_status[0].count;
      end
      seen_down = seen_down | base_status[0].dir;
    end
    check("down phase seen", 1, {31'h0, seen_down});
    wr(`OFS_CTRL, ctl(1'h1, 1'h1, 4'h0, 2'h0, 2'h0), `RESP_OKAY);
    cpu_idle <= 1'h1;
    repeat (3) @(posedge aclk);
    c0 = base_status[0].count;
    repeat (20) @(posedge aclk);
    check("idle halts", {17'h0, c0}, {17'h0, base_status[0].count});
    wr(`OFS_CTRL, ctl(1'h1, 1'h0, 4'h0, 2'h0, 2'h0), `RESP_OKAY);
    c0 = base_status[0].count;
    repeat (3) @(posedge aclk);
    check("idle runs", 1, {31'h0, base_status[0].count !== c0});
    cpu_idle <= 1'h0;
    wr(`OFS_CTRL, 16'h0000, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    c0 = base_status[0].count;
    repeat (20) @(posedge aclk);
    check("stopped count", {17'h0, c0}, {17'h0, base_status[0].count});
    // single pulse: one wrap of period 3, then run drops by itself
    wr(`OFS_COUNT, 16'h0000, `RESP_OKAY);
    wr(`OFS_PERIOD, 16'h0003, `RESP_OKAY);
    wr(`OFS_CTRL, ctl(1'h1, 1'h0, 4'h0, 2'h0, 2'h1), `RESP_OKAY);
    q = 0;
    pm = 0;
    repeat (40) begin
      @(posedge aclk);
      if (base_status[0].base_event === 1'h1) q++;
      if (base_status[0].period_match === 1'h1) pm++;
    end
    check("single pulse events", 1, q);
    check("single period match", 1, pm);
    rd(`OFS_CTRL, 16'h0001, `RESP_OKAY, "single run cleared");
    rd(`OFS_COUNT, 16'h0000, `RESP_OKAY, "single count");
    wr(`OFS_EN, 16'h0001, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq enabled", 1, {31'h0, irq});
    rd(`OFS_STAT, 16'h0001, `RESP_OKAY, "status sticky");
    wr(`OFS_EN, 16'h0000, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq masked", 0, {31'h0, irq});
    wr(`OFS_CLR, 16'h0001, `RESP_OKAY);
    rd(`OFS_CLR, 16'h0000, `RESP_OKAY, "clear reads zero");
    rd(`OFS_STAT, 16'h0000, `RESP_OKAY, "status cleared");
    // second base alone must raise its own bit and leave the first untouched
    wr(`OFS_EN, 16'h0003, `RESP_OKAY);
    wr(`OFS_STEP + `OFS_PERIOD, 16'h0002, `RESP_OKAY);
    wr(`OFS_STEP + `OFS_CTRL, ctl(1'h1, 1'h0, 4'h0, 2'h0, 2'h0), `RESP_OKAY);
    gap_of(1, g);
    check("base1 gap", 3, g);
    rd(`OFS_STAT, 16'h0002, `RESP_OKAY, "base1 status");
    check("irq base1", 1, {31'h0, irq});
    check("base0 idle", 0, {17'h0, base_status[0].count});
    wr(`OFS_STEP + `OFS_CTRL, 16'h0000, `RESP_OKAY);
    wr(`OFS_CLR, 16'h0002, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq cleared", 0, {31'h0, irq});
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
